/* hw/srs_pkg.sv */
package srs_pkg;

  // System clock period and the spike width that the input filter must swallow.
  localparam int CLK_PS = 8000;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FILT_W = $clog2(SPIKE_CYC + 1);
  localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(SPIKE_CYC);

  // Fastest serial clock the protocol logic is sized for.
  localparam int MAX_SCL_KHZ = 1000;

  // Fixed upper six bits of the seven-bit slave address.
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1D;

  // Bit count that closes a byte, and the reset value of every register.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Register map.
  localparam logic [7:0] REG_RESERVED_A = 8'h00;
  localparam logic [7:0] REG_RESERVED_B = 8'h01;
  localparam logic [7:0] REG_BUS_SCRATCH_TEST = 8'h02;
  localparam logic [7:0] REG_INTERRUPT_STATE = 8'h03;
  localparam logic [7:0] REG_SYNC_DETECT_STATE = 8'h04;
  localparam logic [7:0] REG_FRAME_LINE_COUNT_LOW = 8'h05;
  localparam logic [7:0] REG_FRAME_LINE_COUNT_HIGH = 8'h06;
  localparam logic [7:0] REG_LINE_PERIOD_COUNT_LOW = 8'h07;
  localparam logic [7:0] REG_LINE_PERIOD_COUNT_HIGH = 8'h08;
  localparam logic [7:0] REG_PROBE_ROW_LOW = 8'h09;
  localparam logic [7:0] REG_PROBE_ROW_HIGH = 8'h0A;
  localparam logic [7:0] REG_PROBE_COLUMN_LOW = 8'h0B;
  localparam logic [7:0] REG_PROBE_COLUMN_HIGH = 8'h0C;
  localparam logic [7:0] REG_PROBE_COLOUR_LEVEL = 8'h0D;
  localparam logic [7:0] REG_PROBE_RED_SAMPLE = 8'h0E;
  localparam logic [7:0] REG_PROBE_GREEN_SAMPLE = 8'h0F;
  localparam logic [7:0] REG_PROBE_BLUE_SAMPLE = 8'h10;
  localparam logic [7:0] REG_DARK_ROW_COUNT_LOW = 8'h11;
  localparam logic [7:0] REG_DARK_COLUMN_COUNT_LOW = 8'h12;

  typedef enum logic [2:0] {
    SRS_IDLE = 3'h0,
    SRS_ADDR = 3'h1,
    SRS_ADDR_ACK = 3'h3,
    SRS_RX = 3'h2,
    SRS_RX_ACK = 3'h6,
    SRS_TX = 3'h7,
    SRS_TX_ACK = 3'h5,
    SRS_SKIP = 3'h4
  } srs_state_t;

  typedef struct packed {
    logic intr;
    logic [3:0] sync_flags;
    logic [10:0] frame_lines;
    logic [11:0] line_clocks;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] dark_rows;
    logic [7:0] dark_columns;
  } srs_status_t;

  typedef struct packed {
    logic [10:0] row;
    logic [11:0] column;
    logic [7:0] colour;
  } srs_probe_t;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } srs_wr_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] sel_sync;
    logic [FILT_W-1:0] scl_cnt;
    logic [FILT_W-1:0] sda_cnt;
    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    srs_state_t fsm;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] scratch;
    logic rw;
    logic first;
    logic oe;
    srs_probe_t probe;
    srs_wr_t wr;
  } srs_regs_t;

endpackage

/* hw/srs_serial_slave.sv */
`timescale 1ns/100ps
// Contract
// - Works with serial clock up to 1 MHz.
// - Spikes up to 50 ns are filtered out.
// - Slave only; clock line is input only.
// - Data line driven open drain only.
// - Data changes at clock low, sampled rising.
// - Data output released whenever bus is idle.
// - START detected and restarts byte framing.
// - Address 011101 plus select input bit.
// - Own address acknowledged on ninth clock.
// - First write byte loads register pointer.
// - Reads start at last addressed register.
// - Pointer advances after every data byte.
// - Receiver acknowledges every byte on ninth clock.
// - STOP ends transfer, device returns idle.
// - Repeated START restarts address decoding.
// - Registers take effect immediately when written.
// - Storage writes allowed during active processing.
module srs_serial_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_input,
  input srs_pkg::srs_status_t status,
  output srs_pkg::srs_probe_t probe,
  output srs_pkg::srs_wr_t ext_wr
);

  srs_pkg::srs_regs_t s;
  srs_pkg::srs_regs_t next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_byte;
  logic [6:0] own_addr;

  // A level change is accepted only after it has held longer than the spike width.
  function automatic logic [srs_pkg::FILT_W:0] filt_step(
    input logic level,
    input logic samp,
    input logic [srs_pkg::FILT_W-1:0] cnt
  );
    logic [srs_pkg::FILT_W:0] res;
    res = {level, {srs_pkg::FILT_W{1'b0}}};
    if (samp != level) begin
      if (cnt == srs_pkg::FILT_LIMIT) begin
        res = {samp, {srs_pkg::FILT_W{1'b0}}};
      end else begin
        res = {level, srs_pkg::FILT_W'(cnt + 1'b1)};
      end
    end
    return res;
  endfunction

  // Unmapped, reserved and write-only addresses read back as zero.
  function automatic logic [7:0] read_reg(
    input logic [7:0] ptr,
    input srs_pkg::srs_status_t st,
    input logic [7:0] scratch
  );
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      srs_pkg::REG_BUS_SCRATCH_TEST: begin
        v = scratch;
      end
      srs_pkg::REG_INTERRUPT_STATE: begin
        v = {7'h00, st.intr};
      end
      srs_pkg::REG_SYNC_DETECT_STATE: begin
        v = {4'h0, st.sync_flags};
      end
      srs_pkg::REG_FRAME_LINE_COUNT_LOW: begin
        v = st.frame_lines[7:0];
      end
      srs_pkg::REG_FRAME_LINE_COUNT_HIGH: begin
        v = {5'h00, st.frame_lines[10:8]};
      end
      srs_pkg::REG_LINE_PERIOD_COUNT_LOW: begin
        v = st.line_clocks[7:0];
      end
      srs_pkg::REG_LINE_PERIOD_COUNT_HIGH: begin
        v = {4'h0, st.line_clocks[11:8]};
      end
      srs_pkg::REG_PROBE_RED_SAMPLE: begin
        v = st.red;
      end
      srs_pkg::REG_PROBE_GREEN_SAMPLE: begin
        v = st.green;
      end
      srs_pkg::REG_PROBE_BLUE_SAMPLE: begin
        v = st.blue;
      end
      srs_pkg::REG_DARK_ROW_COUNT_LOW: begin
        v = st.dark_rows;
      end
      srs_pkg::REG_DARK_COLUMN_COUNT_LOW: begin
        v = st.dark_columns;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  assign scl_rise = s.scl & ~s.scl_d;
  assign scl_fall = ~s.scl & s.scl_d;
  assign start_seen = s.scl & s.scl_d & s.sda_d & ~s.sda;
  assign stop_seen = s.scl & s.scl_d & ~s.sda_d & s.sda;
  assign own_addr = {srs_pkg::SLAVE_ADDR_HI, s.sel_sync[1]};
  assign rd_byte = read_reg(s.ptr, status, s.scratch);

  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.sel_sync = {s.sel_sync[0], address_select_input};
    // The filter adds about 64 ns of delay, small against a 1 MHz bit time.
    {next_s.scl, next_s.scl_cnt} = filt_step(s.scl, s.scl_sync[1], s.scl_cnt);
    {next_s.sda, next_s.sda_cnt} = filt_step(s.sda, s.sda_sync[1], s.sda_cnt);
    next_s.scl_d = s.scl;
    next_s.sda_d = s.sda;
    next_s.wr.stb = 1'b0;
    if (start_seen) begin
      next_s.fsm = srs_pkg::SRS_ADDR;
      next_s.bits = 4'h0;
      next_s.oe = 1'b0;
    end else if (stop_seen) begin
      next_s.fsm = srs_pkg::SRS_IDLE;
      next_s.bits = 4'h0;
      next_s.oe = 1'b0;
    end else begin
      case (s.fsm)
        srs_pkg::SRS_ADDR,
        srs_pkg::SRS_RX: begin
          if (scl_rise && s.bits != srs_pkg::BYTE_BITS) begin
            next_s.shift = {s.shift[6:0], s.sda};
            next_s.bits = s.bits + 4'h1;
          end else if (scl_fall && s.bits == srs_pkg::BYTE_BITS) begin
            next_s.bits = 4'h0;
            if (s.fsm == srs_pkg::SRS_ADDR) begin
              if (s.shift[7:1] == own_addr) begin
                next_s.rw = s.shift[0];
                next_s.oe = 1'b1;
                next_s.fsm = srs_pkg::SRS_ADDR_ACK;
              end else begin
                next_s.fsm = srs_pkg::SRS_SKIP;
              end
            end else begin
              next_s.oe = 1'b1;
              next_s.fsm = srs_pkg::SRS_RX_ACK;
              if (s.first) begin
                next_s.ptr = s.shift;
                next_s.first = 1'b0;
              end else begin
                // Writes land at once, whatever the device is doing.
                next_s.wr = '{stb: 1'b1, addr: s.ptr, data: s.shift};
                next_s.ptr = s.ptr + 8'h01;
                case (s.ptr)
                  srs_pkg::REG_BUS_SCRATCH_TEST: begin
                    next_s.scratch = s.shift;
                  end
                  srs_pkg::REG_PROBE_ROW_LOW: begin
                    next_s.probe.row[7:0] = s.shift;
                  end
                  srs_pkg::REG_PROBE_ROW_HIGH: begin
                    next_s.probe.row[10:8] = s.shift[2:0];
                  end
                  srs_pkg::REG_PROBE_COLUMN_LOW: begin
                    next_s.probe.column[7:0] = s.shift;
                  end
                  srs_pkg::REG_PROBE_COLUMN_HIGH: begin
                    next_s.probe.column[11:8] = s.shift[3:0];
                  end
                  srs_pkg::REG_PROBE_COLOUR_LEVEL: begin
                    next_s.probe.colour = s.shift;
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
        end
        srs_pkg::SRS_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.bits = 4'h0;
            if (s.rw) begin
              next_s.shift = rd_byte;
              next_s.oe = ~rd_byte[7];
              next_s.fsm = srs_pkg::SRS_TX;
            end else begin
              next_s.oe = 1'b0;
              next_s.first = 1'b1;
              next_s.fsm = srs_pkg::SRS_RX;
            end
          end
        end
        srs_pkg::SRS_RX_ACK: begin
          if (scl_fall) begin
            next_s.oe = 1'b0;
            next_s.fsm = srs_pkg::SRS_RX;
          end
        end
        srs_pkg::SRS_TX: begin
          if (scl_rise) begin
            next_s.bits = s.bits + 4'h1;
          end else if (scl_fall) begin
            if (s.bits == srs_pkg::BYTE_BITS) begin
              next_s.oe = 1'b0;
              next_s.bits = 4'h0;
              next_s.ptr = s.ptr + 8'h01;
              next_s.fsm = srs_pkg::SRS_TX_ACK;
            end else begin
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.oe = ~s.shift[6];
            end
          end
        end
        srs_pkg::SRS_TX_ACK: begin
          if (scl_rise && s.sda) begin
            next_s.fsm = srs_pkg::SRS_SKIP;
          end else if (scl_fall) begin
            next_s.shift = rd_byte;
            next_s.oe = ~rd_byte[7];
            next_s.fsm = srs_pkg::SRS_TX;
          end
        end
        srs_pkg::SRS_SKIP,
        srs_pkg::SRS_IDLE: begin
          next_s.oe = 1'b0;
        end
        default: begin
          next_s.oe = 1'b0;
          next_s.fsm = srs_pkg::SRS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.scl_sync <= 2'h3;
      s.sda_sync <= 2'h3;
      s.scl <= 1'b1;
      s.sda <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
      s.fsm <= srs_pkg::SRS_IDLE;
      s.ptr <= srs_pkg::PTR_RESET;
      s.scratch <= srs_pkg::REG_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // The pin is only ever pulled low; a one is sent by releasing it.
  assign sda_out = 1'b0;
  assign sda_oe = s.oe;
  assign probe = s.probe;
  assign ext_wr = s.wr;

endmodule

/* testbench/srs_chk.sv */
`timescale 1ns/100ps
module srs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input srs_pkg::srs_probe_t probe,
  input srs_pkg::srs_wr_t ext_wr
);
  // Taken from the raw pins, so the block's filter lag never hides a late drive.
  logic busy;
  always_ff @(posedge clk) begin
    if (rst)
      busy <= 1'h0;
    else if (scl_in && $fell(sda_in))
      busy <= 1'h1;
    else if (scl_in && $rose(sda_in))
      busy <= 1'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_OPEN_DRAIN: assert property (sda_out == 1'h0) else $error("sda_out high");
  AST_IDLE_FREE: assert property (!busy |-> !sda_oe) else $error("idle drive");
  AST_CHANGE_LOW: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 8) == 1'h0)
    else $error("drive at high clock");
  AST_HOLD_HIGH: assert property ($rose(scl_in) |=> $stable(sda_oe) [*8])
    else $error("drive moved");
  AST_ACK_WIDTH: assert property ($rose(sda_oe) |=> sda_oe [*8]) else $error("short");
  AST_WR_PULSE: assert property (ext_wr.stb |=> !ext_wr.stb) else $error("long stb");
  AST_WR_BUSY: assert property (ext_wr.stb |-> busy && !scl_in) else $error("stray");
  AST_PROBE_WR: assert property ($changed(probe) |-> ext_wr.stb || $past(ext_wr.stb))
    else $error("probe moved");
  COV_ACK: cover property ($rose(sda_oe));
  COV_WR: cover property (ext_wr.stb && ext_wr.addr == 8'h0D);
  COV_RESTART: cover property (busy && scl_in && $fell(sda_in));
endmodule
bind srs_serial_slave srs_chk chk (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .probe(probe), .ext_wr(ext_wr));

/* testbench/srs_master.sv */
`timescale 1ns/100ps
// Moves only on falling clock edges; a quarter of 32 cycles keeps the clock below 1 MHz.
module srs_master (
  input wire logic clk,
  output logic scl = 1'h1,
  output logic pull = 1'h0,
  input wire logic sda
);
  logic spike = 1'h0;
  task automatic q();
    repeat (32) @(negedge clk);
  endtask
  task automatic start();
    scl = 1'h1;
    q();
    pull = 1'h1;
    q();
    scl = 1'h0;
    q();
  endtask
  task automatic stop();
    pull = 1'h1;
    q();
    scl = 1'h1;
    q();
    pull = 1'h0;
    q();
  endtask
  task automatic bit_x(input logic b, output logic r);
    pull = ~b;
    q();
    if (spike) begin
      scl = 1'h1;
      repeat (6) @(negedge clk);
      scl = 1'h0;
      repeat (6) @(negedge clk);
    end
    scl = 1'h1;
    q();
    r = sda;
    q();
    scl = 1'h0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
    bit_x(last, r);
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sel = 1'h0;
  logic scl, pull, sda_out, sda_oe;
  srs_pkg::srs_status_t status = '0;
  srs_pkg::srs_probe_t probe;
  srs_pkg::srs_wr_t ext_wr;
  int errors = 0;
  int compares = 0;
  int wr_count = 0;
  logic [15:0] last_wr = 16'h0000;
  wire logic sda = !(sda_oe || pull);
  always #4 clk = ~clk;
  srs_serial_slave dut (.clk(clk), .rst(rst), .ce(1'h1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_input(sel), .status(status),
    .probe(probe), .ext_wr(ext_wr));
  srs_master mst (.clk(clk), .scl(scl), .pull(pull), .sda(sda));
  // Every data byte written must leave one strobe with its address and value.
  always @(posedge clk) begin
    if (ext_wr.stb) begin
      wr_count <= wr_count + 1;
      last_wr <= {ext_wr.addr, ext_wr.data};
    end
  end
  initial begin
    repeat (70000) @(posedge clk);
    errors++;
    wrap_up();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b [$]);
    logic a;
    mst.start();
    foreach (b[i]) begin
      mst.wbyte(b[i], a);
      check(32'(a), 32'h1);
    end
  endtask
  task automatic rd(input logic [7:0] exp [$]);
    logic [7:0] d;
    wr('{8'h75});
    foreach (exp[i]) begin
      mst.rbyte(i == exp.size() - 1, d);
      check(32'(d), 32'(exp[i]));
    end
    mst.stop();
  endtask
  task automatic t_write();
    check(32'(probe), 32'h0);
    wr('{8'h74, 8'h09, 8'h55, 8'h03, 8'h34, 8'h0C, 8'h77});
    mst.stop();
    check(32'(probe.row), 32'h355);
    check(32'(probe.column), 32'hC34);
    check(32'(probe.colour), 32'h77);
    check(32'(wr_count), 32'h5);
    check(32'(last_wr), 32'h0D77);
  endtask
  task automatic t_address();
    logic a;
    mst.start();
    mst.wbyte(8'h76, a);
    mst.wbyte(8'h09, a);
    check(32'(a), 32'h0);
    mst.stop();
    sel = 1'h1;
    wr('{8'h76});
    mst.stop();
    sel = 1'h0;
    mst.spike = 1'h1;
    wr('{8'h74, 8'h0B, 8'hE7});
    mst.stop();
    check(32'({probe.row, probe.column[7:0]}), 32'h355E7);
  endtask
  task automatic t_read();
    status = '{1'h1, 4'hA, 11'h5C3, 12'h9E1, 8'h3C, 8'hC6, 8'h5A, 8'h81, 8'h7E};
    wr('{8'h74, 8'h00});
    rd('{8'h00, 8'h00, 8'h00});
    wr('{8'h74, 8'h02, 8'hA5});
    wr('{8'h74, 8'h02});
    rd('{8'hA5, 8'h01, 8'h0A, 8'hC3, 8'h05, 8'hE1, 8'h09, 8'h00});
    wr('{8'h74, 8'h0E});
    rd('{8'h3C, 8'hC6});
    rd('{8'h5A, 8'h81, 8'h7E, 8'h00});
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'h0;
    repeat (12) @(negedge clk);
    t_write();
    t_address();
    t_read();
    wrap_up();
  end
endmodule
